// *** design/dmrc_ctrl.sv ***
// Summary of operation
// - Sample the zero flag only after it settles past the count fall.
// - Refresh one row per period over 64, then pulse count.
// - Count may pulse inside a refresh cycle after address hold time.
// - Burst holds refresh select high, counting until zero flag low.
`timescale 1ns/100ps
`default_nettype none

module dmrc_ctrl
  import dmrc_pkg::*;
#(
  parameter int REF_INTERVAL = ROW_INT_CYC,
  parameter int REF_CYC_LEN  = CNT_PER_CYC,
  parameter int ROW_CYC_LEN  = 8,
  parameter int COL_CYC_LEN  = 8,
  parameter int T_HOLD_NS    = 20
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [SYS_W-1:0] SYS_ADDR,
  input  wire logic             ACC_REQ,
  input  wire logic             BURST_REQ,
  input  wire logic             DIST_EN,
  input  wire logic             EARLY_COUNT,
  input  wire logic             ZERO_N,
  output dmrc_dev_t             DEV,
  output logic                  REF_CYCLE,
  output logic                  MEM_CYCLE,
  output logic                  ACC_ACK,
  output logic                  ACC_DONE,
  output logic                  BURST_DONE
);

  // ==========================================================================
  // Derived counts and elaboration checks
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // The refresh cycle itself spaces count pulses, so it must cover the
  // counter's maximum rate and leave room for an early pulse inside it.
  if (REF_CYC_LEN < CNT_PER_CYC || REF_CYC_LEN < HOLD_CYC + CPW_CYC + 2 ||
      REF_CYC_LEN >= (1 << TMR_W) || ROW_CYC_LEN < 1 ||
      COL_CYC_LEN < 1 || CPW_CYC >= (1 << CPW_W)) begin : g_chk
    $error("Controller timing parameters out of range.");
  end

  localparam logic [TMR_W-1:0] REF_LAST  = TMR_W'(REF_CYC_LEN - 1);
  localparam logic [TMR_W-1:0] ROW_LAST  = TMR_W'(ROW_CYC_LEN - 1);
  localparam logic [TMR_W-1:0] COL_LAST  = TMR_W'(COL_CYC_LEN - 1);
  localparam logic [TMR_W-1:0] SET_LAST  = TMR_W'(SETTLE_CYC - 1);
  localparam logic [TMR_W-1:0] HOLD_AT   = TMR_W'(REF_CYC_LEN - 1 - HOLD_CYC);
  localparam logic [CPW_W-1:0] CPW_LOAD  = CPW_W'(CPW_CYC);

  // ==========================================================================
  // Row interval divider
  logic tick;

  dmrc_tick #(
    .INTERVAL (REF_INTERVAL)
  ) u_tick (
    .CLK   (CLK),
    .RESET (RESET),
    .TICK  (tick)
  );

  // ==========================================================================
  // Sequencer
  dmrc_ctl_t r_reg;
  dmrc_ctl_t r_next;

  always_comb begin
    r_next            = r_reg;
    r_next.acc_ack    = 1'b0;
    r_next.acc_done   = 1'b0;
    r_next.burst_done = 1'b0;
    // Glitches on the flag are absorbed by requiring two stages to agree.
    r_next.zsync      = {r_reg.zsync[1:0], ZERO_N};
    if (r_reg.zsync[1] == r_reg.zsync[2]) begin
      r_next.zero_n = r_reg.zsync[2];
    end
    if (r_reg.cpw != '0) begin
      r_next.cpw = r_reg.cpw - 1'b1;
    end
    if (r_reg.timer != '0) begin
      r_next.timer = r_reg.timer - 1'b1;
    end
    unique case (r_reg.st)
      ST_IDLE: begin
        if (r_reg.burst_pend) begin
          r_next.burst_pend = 1'b0;
          r_next.burst_act  = 1'b1;
          r_next.st         = ST_REF_CYC;
          r_next.timer      = REF_LAST;
          r_next.cnt_sent   = 1'b0;
        end else if (r_reg.ref_pend) begin
          r_next.ref_pend = 1'b0;
          r_next.st       = ST_REF_CYC;
          r_next.timer    = REF_LAST;
          r_next.cnt_sent = 1'b0;
        end else if (ACC_REQ) begin
          r_next.addr    = SYS_ADDR;
          r_next.acc_ack = 1'b1;
          r_next.st      = ST_ACC_ROW;
          r_next.timer   = ROW_LAST;
        end
      end
      ST_ACC_ROW: begin
        if (r_reg.timer == '0) begin
          r_next.st    = ST_ACC_COL;
          r_next.timer = COL_LAST;
        end
      end
      ST_ACC_COL: begin
        if (r_reg.timer == '0) begin
          r_next.st       = ST_IDLE;
          r_next.acc_done = 1'b1;
        end
      end
      ST_REF_CYC: begin
        if (EARLY_COUNT && !r_reg.cnt_sent && r_reg.timer == HOLD_AT) begin
          r_next.cpw      = CPW_LOAD;
          r_next.cnt_sent = 1'b1;
        end
        if (r_reg.timer == '0) begin
          if (r_reg.cnt_sent) begin
            r_next.st    = ST_SETTLE;
            r_next.timer = SET_LAST;
          end else begin
            r_next.st  = ST_CNT_LOW;
            r_next.cpw = CPW_LOAD;
          end
        end
      end
      ST_CNT_LOW: begin
        if (r_reg.cpw == CPW_W'(1)) begin
          r_next.st    = ST_SETTLE;
          r_next.timer = SET_LAST;
        end
      end
      ST_SETTLE: begin
        if (r_reg.timer == '0 && r_reg.cpw == '0) begin
          if (r_reg.burst_act && r_reg.zero_n) begin
            r_next.st       = ST_REF_CYC;
            r_next.timer    = REF_LAST;
            r_next.cnt_sent = 1'b0;
          end else begin
            r_next.st = ST_IDLE;
            if (r_reg.burst_act) begin
              r_next.burst_act  = 1'b0;
              r_next.burst_done = 1'b1;
            end
          end
        end
      end
    endcase
    // Requests arriving while a pending flag is taken are kept.
    if (tick && DIST_EN) begin
      r_next.ref_pend = 1'b1;
    end
    if (BURST_REQ) begin
      r_next.burst_pend = 1'b1;
    end
    r_next.dev.refresh_en  = (r_next.st == ST_REF_CYC) ||
                             (r_next.st == ST_CNT_LOW) ||
                             (r_next.st == ST_SETTLE);
    r_next.dev.row_en      = (r_next.st != ST_ACC_COL);
    r_next.dev.count_n     = (r_next.cpw == '0);
    r_next.dev.row_addr_in = r_next.addr[ROW_LSB +: HALF_W];
    r_next.dev.col_addr_in = r_next.addr[COL_LSB +: HALF_W];
    r_next.ref_cycle       = (r_next.st == ST_REF_CYC);
    r_next.mem_cycle       = (r_next.st == ST_ACC_ROW) ||
                             (r_next.st == ST_ACC_COL);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      r_reg             <= '0;
      r_reg.st          <= ST_IDLE;
      r_reg.zsync       <= 3'h7;
      r_reg.zero_n      <= 1'b1;
      r_reg.dev.row_en  <= 1'b1;
      r_reg.dev.count_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign DEV        = r_reg.dev;
  assign REF_CYCLE  = r_reg.ref_cycle;
  assign MEM_CYCLE  = r_reg.mem_cycle;
  assign ACC_ACK    = r_reg.acc_ack;
  assign ACC_DONE   = r_reg.acc_done;
  assign BURST_DONE = r_reg.burst_done;

  // ==========================================================================
  // Checks
  logic [7:0] since_fall;
  logic [7:0] ref_age;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      since_fall <= 8'hff;
      ref_age    <= 8'h00;
    end else begin
      if (r_reg.dev.count_n && !r_next.dev.count_n) begin
        since_fall <= 8'h00;
      end else if (since_fall != 8'hff) begin
        since_fall <= since_fall + 8'h01;
      end
      ref_age <= r_next.ref_cycle ? ref_age + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_ref_end;
    $fell(REF_CYCLE) && !$past(r_reg.cnt_sent);
  endsequence

  sequence s_count_pulse;
    (!DEV.count_n) [*7] ##1 DEV.count_n;
  endsequence

  count_after_ref_a: assert property (s_ref_end |-> s_count_pulse)
    else $error("Count pulse missing or wrong width after refresh.");

  early_hold_a: assert property (
    $fell(DEV.count_n) && REF_CYCLE |-> ref_age >= 8'(HOLD_CYC))
    else $error("Count pulse inside refresh before hold time.");

  zero_settle_a: assert property (
    BURST_DONE |-> since_fall >= 8'(CPW_CYC + CZ_CYC))
    else $error("Zero flag sampled before it settled.");

  burst_hold_a: assert property (
    r_reg.burst_act |-> DEV.refresh_en)
    else $error("Refresh select dropped during burst.");

  burst_end_a: assert property (
    $fell(r_reg.burst_act) |-> BURST_DONE && !$past(r_reg.zero_n))
    else $error("Burst ended without zero flag low.");

  dist_start_a: assert property (
    tick && DIST_EN && r_reg.st == ST_IDLE && !r_reg.burst_pend &&
    !r_reg.burst_act |-> ##[1:64] REF_CYCLE)
    else $error("Distributed refresh not started after interval.");

endmodule : dmrc_ctrl

`default_nettype wire

// *** design/dmrc_pkg.sv ***
package dmrc_pkg;

  // ==========================================================================
  // Clock and device timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int T_CPW_NS       = 35;
  localparam int T_CZ_NS        = 70;
  localparam int T_CNT_PER_NS   = 200;
  localparam int T_REFRESH_NS   = 2000000;
  localparam int REFRESH_ROWS   = 64;
  localparam int T_ROW_INT_NS   = T_REFRESH_NS / REFRESH_ROWS;
  localparam int CPW_CYC        = (T_CPW_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int CZ_CYC         = (T_CZ_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int CNT_PER_CYC    = (T_CNT_PER_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int ROW_INT_CYC    = T_ROW_INT_NS / CLK_PERIOD_NS;
  localparam int SYNC_LAT       = 3;
  localparam int SETTLE_CYC     = CZ_CYC + SYNC_LAT;

  // ==========================================================================
  // Widths and field positions
  localparam int HALF_W         = 6;
  localparam int SYS_W          = 2 * HALF_W;
  localparam int ROW_LSB        = 0;
  localparam int COL_LSB        = HALF_W;
  localparam int TMR_W          = 16;
  localparam int CPW_W          = 4;
  localparam int INT_W          = 16;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACC_ROW,
    ST_ACC_COL,
    ST_REF_CYC,
    ST_CNT_LOW,
    ST_SETTLE
  } dmrc_state_t;

  typedef struct packed {
    logic              refresh_en;
    logic              row_en;
    logic              count_n;
    logic [HALF_W-1:0] row_addr_in;
    logic [HALF_W-1:0] col_addr_in;
  } dmrc_dev_t;

  typedef struct packed {
    dmrc_state_t       st;
    logic [TMR_W-1:0]  timer;
    logic [CPW_W-1:0]  cpw;
    logic              cnt_sent;
    logic              ref_pend;
    logic              burst_pend;
    logic              burst_act;
    logic [2:0]        zsync;
    logic              zero_n;
    logic [SYS_W-1:0]  addr;
    dmrc_dev_t         dev;
    logic              ref_cycle;
    logic              mem_cycle;
    logic              acc_ack;
    logic              acc_done;
    logic              burst_done;
  } dmrc_ctl_t;

  typedef struct packed {
    logic [INT_W-1:0]  cnt;
    logic              tick;
  } dmrc_tick_st_t;

endpackage : dmrc_pkg

// *** design/dmrc_tick.sv ***
`timescale 1ns/100ps
`default_nettype none

module dmrc_tick
  import dmrc_pkg::*;
#(
  parameter int INTERVAL = ROW_INT_CYC
) (
  input  wire logic CLK,
  input  wire logic RESET,
  output logic      TICK
);

  // ==========================================================================
  // Interval divider
  if (INTERVAL < 2 || INTERVAL >= (1 << INT_W)) begin : g_chk
    $error("Interval out of range.");
  end

  localparam logic [INT_W-1:0] LAST = INT_W'(INTERVAL - 1);

  dmrc_tick_st_t r_reg;
  dmrc_tick_st_t r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == LAST) begin
      r_next.cnt  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign TICK = r_reg.tick;

endmodule : dmrc_tick

`default_nettype wire

// *** tb/dmrc_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module dmrc_dev_model
  import dmrc_pkg::*;
#(
  parameter logic [HALF_W-1:0] INIT = 6'h3c
) (
  input  wire dmrc_dev_t    dev,
  output logic [HALF_W-1:0] mem_addr_out_n,
  output logic              zero_n
);
  // ==========================================================================
  // Refresh counter
  // The power-up value is fixed by INIT, since the counter has no reset.
  logic [HALF_W-1:0] cnt_reg = INIT;
  logic              glitch  = 1'b0;
  logic              spike   = 1'b0;

  // The flag toggles until the decode has settled, so early sampling fails.
  always @(negedge dev.count_n) begin
    cnt_reg = cnt_reg + 6'h01;
    glitch = 1'b1;
    repeat (T_CZ_NS / CLK_PERIOD_NS) #(CLK_PERIOD_NS) spike = ~spike;
    glitch = 1'b0;
  end

  assign zero_n = glitch ? spike : (cnt_reg != 6'h00);

  // ==========================================================================
  // Address selection
  always_comb begin
    if (dev.refresh_en) begin
      mem_addr_out_n = ~(cnt_reg & {HALF_W{dev.refresh_en}});
    end else if (dev.row_en) begin
      mem_addr_out_n = ~dev.row_addr_in;
    end else begin
      mem_addr_out_n = ~dev.col_addr_in;
    end
  end
endmodule : dmrc_dev_model

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import dmrc_pkg::*;
  localparam int                INTV = 200;
  localparam logic [HALF_W-1:0] INIT = 6'h3c;

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [SYS_W-1:0]  sys_addr = 12'h000;
  logic              acc_req = 1'b0;
  logic              burst_req = 1'b0;
  logic              dist_en = 1'b0;
  logic              early_count = 1'b0;
  wire logic         zero_n;
  dmrc_dev_t         dev;
  logic              ref_cycle, mem_cycle, acc_ack, acc_done, burst_done;
  wire logic [5:0]   mem_addr_out_n;
  int                err_total = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                last_rise = 0;
  logic [HALF_W-1:0] exp_cnt = INIT;

  always #2.5 clk = ~clk;

  dmrc_ctrl #(.REF_INTERVAL(INTV)) u_dmrc_ctrl (
    .CLK(clk), .RESET(rst), .SYS_ADDR(sys_addr), .ACC_REQ(acc_req),
    .BURST_REQ(burst_req), .DIST_EN(dist_en), .EARLY_COUNT(early_count),
    .ZERO_N(zero_n), .DEV(dev), .REF_CYCLE(ref_cycle),
    .MEM_CYCLE(mem_cycle), .ACC_ACK(acc_ack), .ACC_DONE(acc_done),
    .BURST_DONE(burst_done));

  dmrc_dev_model #(.INIT(INIT)) u_dmrc_dev_model (
    .dev(dev), .mem_addr_out_n(mem_addr_out_n), .zero_n(zero_n));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // The ceiling is far above the few hundred cycles the tests need.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end

  // ==========================================================================
  // Scenarios
  task automatic test_access(input logic [11:0] a);
    sys_addr = a;
    acc_req = 1'b1;
    @(negedge clk);
    while (acc_ack !== 1'b1) @(negedge clk);
    acc_req = 1'b0;
    check({dev.col_addr_in, dev.row_addr_in}, a);
    check(12'(mem_addr_out_n), {6'h00, ~a[5:0]});
    check(12'(mem_cycle), 12'h001);
    repeat (8) @(negedge clk);
    check(12'(dev.row_en), 12'h000);
    check(12'(mem_addr_out_n), {6'h00, ~a[11:6]});
    repeat (8) @(negedge clk);
    check(12'(acc_done), 12'h001);
    check(12'(mem_cycle), 12'h000);
    $display("test access %h done", a);
  endtask : test_access

  task automatic test_dist(input logic early);
    int age, fall, low, t0;
    early_count = early;
    dist_en = 1'b1;
    while (ref_cycle !== 1'b1) @(negedge clk);
    t0 = cyc;
    // Only one interval is taken per call, so no stray refresh follows.
    dist_en = 1'b0;
    check(12'(dev.refresh_en), 12'h001);
    check(12'(mem_addr_out_n), {6'h00, ~exp_cnt});
    if (early) check(12'(t0 - last_rise), 12'(INTV));
    last_rise = t0;
    age = 0;
    fall = 0;
    low = 0;
    while (dev.refresh_en === 1'b1) begin
      if (dev.count_n === 1'b0) begin
        if (low == 0) fall = age;
        if (low == 0) check(12'(ref_cycle), 12'(early));
        low++;
      end
      age++;
      @(negedge clk);
    end
    check(12'(fall), early ? 12'h005 : 12'(CNT_PER_CYC));
    check(12'(low), 12'(CPW_CYC));
    check(12'(zero_n), 12'h001);
    exp_cnt = exp_cnt + 6'h01;
    $display("test distributed refresh early=%0b done", early);
  endtask : test_dist

  task automatic test_burst;
    int rows, bad;
    logic prev;
    rows = 0;
    bad = 0;
    prev = 1'b0;
    early_count = 1'b0;
    burst_req = 1'b1;
    @(negedge clk);
    burst_req = 1'b0;
    while (burst_done !== 1'b1) begin
      if (ref_cycle === 1'b1 && !prev) rows++;
      if (rows > 0 && dev.refresh_en !== 1'b1) bad++;
      prev = ref_cycle;
      @(negedge clk);
    end
    check(12'(bad), 12'h000);
    check(12'(rows), 12'(64 - exp_cnt));
    check(12'(zero_n), 12'h000);
    check(12'(dev.refresh_en), 12'h000);
    $display("test burst refresh done");
  endtask : test_burst

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({dev.row_en, dev.count_n, dev.refresh_en, ref_cycle}, 12'h00c);
    test_access(12'ha5c);
    test_access(12'h5a3);
    test_dist(1'b0);
    test_dist(1'b1);
    test_burst;
    test_access(12'hfc0);
    test_done;
  end
endmodule : testbench

`default_nettype wire
